// File: src/multifunction_latch_watchdog_pkg.sv
// How it works
// - Write-only 8-bit latch at 0x2B0; writes set all bits, reads return zero.
// - Bit 0 drives the LCD write strobe, high after reset.
// - Bit 1 drives the LCD command/data select, low after reset.
// - Bit 2 drives the LCD enable line, high after reset.
// - Bits 3, 4, 5 drive EEPROM data, second line, clock; low after reset.
// - Bit 6 is stored, reset low, and drives nothing.
// - Bit 7 drives the watchdog kick, low after reset.
// - Watchdog is off after reset and never resets until enabled.
// - Enabled watchdog needs a kick every 800 ms or it resets the system.
// - Flash disk is claimed through the 64k window D0000 to DFFFF.
// - With only an IDE flash drive fitted, the window is not claimed.
// - Gate jumper open means the watchdog can never reset the system.
// - Jumper picks LCD lines from latch or CPU strobes and address bit 0.
`default_nettype none

package multifunction_latch_watchdog_pkg;

  // Register map, byte addresses
  localparam logic [11:0] LATCH_ADDR  = 12'h2B0;
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;

  // Latch layout and reset value
  localparam int          LCD_WR_BIT   = 0;
  localparam int          LCD_CD_BIT   = 1;
  localparam int          LCD_EN_BIT   = 2;
  localparam int          EE_DATA_BIT  = 3;
  localparam int          EE_SEC_BIT   = 4;
  localparam int          EE_CLK_BIT   = 5;
  localparam int          KICK_BIT     = 7;
  localparam logic [7:0]  LATCH_RESET  = 8'h05;

  // Control register fields
  localparam int          CTRL_WD_EN_BIT    = 0;
  localparam int          CTRL_IDE_ONLY_BIT = 1;

  // Status register fields
  localparam int          STAT_WD_EN_BIT    = 0;
  localparam int          STAT_EXPIRED_BIT  = 1;
  localparam int          STAT_GATE_BIT     = 2;
  localparam int          STAT_RESET_BIT    = 3;

  // Flash window: upper address nibble of the D segment
  localparam logic [3:0]  FLASH_SEG    = 4'hD;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Watchdog timing
  localparam int          CLK_MHZ            = 100;
  localparam int          WD_TIMEOUT_MS      = 800;
  localparam int          WD_TIMEOUT_CYCLES  = WD_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int          RESET_PULSE_CYCLES = 16;

endpackage

`default_nettype wire

// File: src/multifunction_latch_watchdog.sv
`timescale 1ns/1ns
`default_nettype none

module multifunction_latch_watchdog #(
  parameter int TIMEOUT_CYCLES = multifunction_latch_watchdog_pkg::WD_TIMEOUT_CYCLES,
  parameter int PULSE_CYCLES   = multifunction_latch_watchdog_pkg::RESET_PULSE_CYCLES,
  parameter int CNT_W          = 27
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Board jumpers
  input  wire logic        watchdog_gate_jumper_i,
  input  wire logic        lcd_source_select_jumper_i,
  // CPU strobes for direct LCD mode
  input  wire logic        cpu_iow_n_i,
  input  wire logic        cpu_ior_n_i,
  input  wire logic        cpu_sa0_i,
  // Host memory cycle for the flash window
  input  wire logic [19:0] mem_addr_i,
  input  wire logic        mem_cycle_i,
  output logic             flash_window_sel_o,
  // Latch driven lines and system reset
  output logic             lcd_write_strobe_o,
  output logic             lcd_cmd_data_select_o,
  output logic             lcd_enable_line_o,
  output logic             eeprom_data_o,
  output logic             eeprom_second_line_o,
  output logic             eeprom_clock_o,
  output logic             watchdog_kick_o,
  output logic             system_reset_o
);
  import multifunction_latch_watchdog_pkg::*;

  localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [4:0]       PULSE_LOAD   = 5'(PULSE_CYCLES);

  // Write channel holding registers
  logic        aw_have_q;
  logic [11:0] awaddr_q;
  logic        w_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  // Read channel registers
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  // Block state
  logic [7:0]       latch_q;
  logic             wd_en_q;
  logic             ide_only_q;
  logic             expired_q;
  logic             kick_prev_q;
  logic [CNT_W-1:0] cnt_q;
  logic [4:0]       pulse_q;

  // Address decode helper
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] reg_addr);
    addr_hit = (a[11:2] == reg_addr[11:2]);
  endfunction

  // Channel handshakes
  wire aw_take  = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take   = s_axi_wvalid_i && s_axi_wready_o;
  wire ar_take  = s_axi_arvalid_i && s_axi_arready_o;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;

  // Write target decode
  wire wr_latch  = do_write && addr_hit(awaddr_q, LATCH_ADDR);
  wire wr_ctrl   = do_write && addr_hit(awaddr_q, CTRL_ADDR);
  wire wr_status = do_write && addr_hit(awaddr_q, STATUS_ADDR);
  wire wr_known  = wr_latch || wr_ctrl || wr_status;

  // Read decode
  wire rd_latch  = addr_hit(s_axi_araddr_i, LATCH_ADDR);
  wire rd_ctrl   = addr_hit(s_axi_araddr_i, CTRL_ADDR);
  wire rd_status = addr_hit(s_axi_araddr_i, STATUS_ADDR);
  wire [31:0] ctrl_word = {30'h0, ide_only_q, wd_en_q};
  wire [31:0] stat_word = {28'h0, system_reset_o, watchdog_gate_jumper_i, expired_q, wd_en_q};
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_status ? stat_word : 32'h0);
  wire [1:0]  rd_resp = (rd_latch || rd_ctrl || rd_status) ? RESP_OKAY : RESP_SLVERR;

  // Bus outputs
  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  // Write address and data capture, response
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read response
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_resp;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= LATCH_RESET;
    end else if (wr_latch && wstrb_q[0]) begin
      latch_q <= wdata_q[7:0];
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_en_q    <= 1'b0;
      ide_only_q <= 1'b0;
    end else if (wr_ctrl && wstrb_q[0]) begin
      wd_en_q    <= wdata_q[CTRL_WD_EN_BIT];
      ide_only_q <= wdata_q[CTRL_IDE_ONLY_BIT];
    end
  end

  // rising edge of the kick bit
  wire kick_rise = latch_q[KICK_BIT] && !kick_prev_q;
  // counting only when enabled and gated in
  wire wd_armed  = wd_en_q && watchdog_gate_jumper_i;
  wire wd_fire   = wd_armed && !kick_rise && (cnt_q == TIMEOUT_LAST);

  // Watchdog counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kick_prev_q <= 1'b0;
      cnt_q       <= '0;
    end else begin
      kick_prev_q <= latch_q[KICK_BIT];
      if (!wd_armed || kick_rise || wd_fire) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Reset pulse and sticky expiry flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_q   <= 5'h00;
      expired_q <= 1'b0;
    end else begin
      if (wd_fire) begin
        pulse_q <= PULSE_LOAD;
      end else if (pulse_q != 5'h00) begin
        pulse_q <= pulse_q - 5'h01;
      end
      if (wd_fire) begin
        expired_q <= 1'b1;
      end else if (wr_status && wstrb_q[0] && wdata_q[STAT_EXPIRED_BIT]) begin
        expired_q <= 1'b0;
      end
    end
  end

  assign system_reset_o = (pulse_q != 5'h00);

  assign lcd_write_strobe_o    = lcd_source_select_jumper_i ? cpu_iow_n_i : latch_q[LCD_WR_BIT];
  assign lcd_cmd_data_select_o = lcd_source_select_jumper_i ? cpu_sa0_i : latch_q[LCD_CD_BIT];
  assign lcd_enable_line_o     = lcd_source_select_jumper_i ? cpu_ior_n_i : latch_q[LCD_EN_BIT];
  // EEPROM lines and watchdog kick; bit 6 left unrouted
  assign eeprom_data_o        = latch_q[EE_DATA_BIT];
  assign eeprom_second_line_o = latch_q[EE_SEC_BIT];
  assign eeprom_clock_o       = latch_q[EE_CLK_BIT];
  assign watchdog_kick_o      = latch_q[KICK_BIT];

  assign flash_window_sel_o = mem_cycle_i && !ide_only_q && (mem_addr_i[19:16] == FLASH_SEG);

  // Checks
  property p_latch_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_latch && wstrb_q[0]) |=> (latch_q == $past(wdata_q[7:0]));
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost");

  property p_latch_read_zero;
    @(posedge clk_i) disable iff (rst_i)
      (ar_take && rd_latch) |=> (s_axi_rvalid_o && s_axi_rdata_o == 32'h0);
  endproperty
  a_latch_read_zero: assert property (p_latch_read_zero) else $error("latch read not zero");

  property p_reset_values;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (latch_q == LATCH_RESET && !wd_en_q && !system_reset_o);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad latch reset value");

  property p_wd_off;
    @(posedge clk_i) disable iff (rst_i)
      $rose(system_reset_o) |-> $past(wd_en_q, 1);
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("reset while watchdog off");

  property p_timeout_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wd_fire |=> system_reset_o [*4] ##1 expired_q;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse) else $error("no reset after timeout");

  property p_gate_open;
    @(posedge clk_i) disable iff (rst_i)
      !watchdog_gate_jumper_i |-> (!wd_fire && cnt_q == '0) or $past(watchdog_gate_jumper_i);
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("watchdog ran with gate open");

  property p_kick_restart;
    @(posedge clk_i) disable iff (rst_i)
      $rose(latch_q[KICK_BIT]) |=> (cnt_q == '0) && !$rose(system_reset_o) ##1
                                   (cnt_q <= CNT_W'(1));
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart");

  property p_window;
    @(posedge clk_i) disable iff (rst_i)
      flash_window_sel_o |-> (mem_addr_i[19:16] == FLASH_SEG && mem_cycle_i);
  endproperty
  a_window: assert property (p_window) else $error("window claimed outside D segment");

  property p_ide_only;
    @(posedge clk_i) disable iff (rst_i)
      ide_only_q |-> !flash_window_sel_o;
  endproperty
  a_ide_only: assert property (p_ide_only) else $error("window claimed in IDE-only mode");

  property p_lcd_mux;
    @(posedge clk_i) disable iff (rst_i)
      lcd_source_select_jumper_i |-> (lcd_write_strobe_o == cpu_iow_n_i &&
                                      lcd_cmd_data_select_o == cpu_sa0_i);
  endproperty
  a_lcd_mux: assert property (p_lcd_mux) else $error("LCD lines not from CPU");

  property p_bvalid_hold;
    @(posedge clk_i) disable iff (rst_i)
      (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");

endmodule // multifunction_latch_watchdog

`default_nettype wire

// File: verif/reset_sink_model.sv
`timescale 1ns/1ns
`default_nettype none

// Board reset circuit: counts reset pulses and the width of the last one
module reset_sink_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sys_rst_i,
  output var  int   pulses_o,
  output var  int   width_o
);
  logic prev_q;

  // Rising edge count and high-cycle width
  always_ff @(posedge clk_i) begin
    prev_q <= sys_rst_i;
    if (rst_i) begin
      pulses_o <= 0;
      width_o  <= 0;
    end else if (sys_rst_i && !prev_q) begin
      pulses_o <= pulses_o + 1;
      width_o  <= 1;
    end else if (sys_rst_i) begin
      width_o <= width_o + 1;
    end
  end
endmodule // reset_sink_model

`default_nettype wire

// File: verif/multifunction_latch_watchdog_test.sv
`timescale 1ns/1ns
`default_nettype none

module multifunction_latch_watchdog_test;
  import multifunction_latch_watchdog_pkg::*;
  localparam int T = 50;
  logic        clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
  logic        gate, lsel, iow_n, ior_n, sa0, mcyc;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [19:0] maddr;
  wire         awready, wready, bvalid, arready, rvalid, fsel;
  wire         wr, cd, en, ed, es, ec, kick, srst;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  outs = {kick, 1'b0, ec, es, ed, en, cd, wr};
  int          n_mismatch, n_compared, pulses, width;
  logic [7:0]  lp [4] = '{8'hFF, 8'hAA, 8'h55, 8'h40};
  logic [19:0] fa [5] = '{20'hD0000, 20'hDFFFF, 20'hCFFFF, 20'hE0000, 20'h0D000};
  logic [4:0]  fe = 5'b00011;

  multifunction_latch_watchdog #(.TIMEOUT_CYCLES(T), .PULSE_CYCLES(16)) uut (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .watchdog_gate_jumper_i(gate), .lcd_source_select_jumper_i(lsel),
    .cpu_iow_n_i(iow_n), .cpu_ior_n_i(ior_n), .cpu_sa0_i(sa0),
    .mem_addr_i(maddr), .mem_cycle_i(mcyc), .flash_window_sel_o(fsel),
    .lcd_write_strobe_o(wr), .lcd_cmd_data_select_o(cd), .lcd_enable_line_o(en),
    .eeprom_data_o(ed), .eeprom_second_line_o(es), .eeprom_clock_o(ec),
    .watchdog_kick_o(kick), .system_reset_o(srst));

  reset_sink_model board (.clk_i(clk_i), .rst_i(rst_i), .sys_rst_i(srst),
    .pulses_o(pulses), .width_o(width));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Bus write, response compared with er
  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int         n;
    logic       aw, w, ok;
    logic [1:0] r;
    @(posedge clk_i);
    aw = 1;
    w = 1;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_i);
      n++;
      ok = bvalid;
      r = bresp;
      if (aw && awready) begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end while (!ok && n < 50);
    bready <= 0;
    #1;
    chk("bvalid", ok, 1);
    chk("bresp", r, er);
  endtask

  // Bus read, data and response compared
  task automatic axr(input logic [11:0] a, input logic [31:0] ed_v, input logic [1:0] er);
    int          n;
    logic        ok;
    logic [31:0] dv;
    logic [1:0]  r;
    @(posedge clk_i);
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_i);
      n++;
      ok = rvalid;
      dv = rdata;
      r = rresp;
      if (arready) arvalid <= 0;
    end while (!ok && n < 50);
    rready <= 0;
    #1;
    chk("rvalid", ok, 1);
    chk("rdata", dv, ed_v);
    chk("rresp", r, er);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {rst_i, awvalid, wvalid, bready, arvalid, rready, lsel, sa0, mcyc} = 9'h100;
    {gate, iow_n, ior_n} = 3'h7;
    {awaddr, araddr, wdata, maddr} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    #1;
    chk("reset_outs", outs, 8'h05);
    chk("reset_srst", srst, 0);
    for (int i = 0; i < 4; i++) begin
      axw(LATCH_ADDR, lp[i], RESP_OKAY);
      chk("latch_outs", outs, lp[i] & 8'hBF);
    end
    axr(LATCH_ADDR, 0, RESP_OKAY);
    axr(12'h100, 0, RESP_SLVERR);
    axw(12'h100, 8'hFF, RESP_SLVERR);
    chk("unmapped_outs", outs, 8'h00);
    lsel <= 1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      iow_n <= i[0];
      sa0 <= !i[0];
      ior_n <= i[0];
      #1;
      chk("lcd_cpu", {en, cd, wr}, {i[0], !i[0], i[0]});
    end
    @(posedge clk_i);
    lsel <= 0;
    // Host leaves the D segment unshadowed: cycles reach the block
    mcyc <= 1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      maddr <= fa[i];
      #1;
      chk("flash_sel", fsel, fe[i]);
    end
    // Park the host on a D-segment address so the IDE-only switch matters
    maddr <= fa[1];
    axw(CTRL_ADDR, 8'h02, RESP_OKAY);
    chk("ide_only_sel", fsel, 0);
    axw(CTRL_ADDR, 8'h00, RESP_OKAY);
    chk("window_back", fsel, 1);
    repeat (3 * T) @(posedge clk_i);
    chk("wd_off_pulses", pulses, 0);
    gate <= 0;
    axw(CTRL_ADDR, 8'h01, RESP_OKAY);
    repeat (3 * T) @(posedge clk_i);
    chk("gate_open_pulses", pulses, 0);
    gate <= 1;
    // Host kicks well inside the timeout
    for (int i = 0; i < 6; i++) begin
      axw(LATCH_ADDR, 8'h80, RESP_OKAY);
      axw(LATCH_ADDR, 8'h05, RESP_OKAY);
    end
    axw(LATCH_ADDR, 8'h80, RESP_OKAY);
    chk("kicked_pulses", pulses, 0);
    repeat (T - 6) @(posedge clk_i);
    chk("early_pulses", pulses, 0);
    for (int i = 0; i < 30 && pulses == 0; i++) @(posedge clk_i);
    chk("expiry_pulses", pulses, 1);
    repeat (18) @(posedge clk_i);
    chk("pulse_width", width, 16);
    axr(STATUS_ADDR, 32'h7, RESP_OKAY);
    axw(STATUS_ADDR, 8'h02, RESP_OKAY);
    axr(STATUS_ADDR, 32'h5, RESP_OKAY);
    axw(CTRL_ADDR, 8'h00, RESP_OKAY);
    // Mid-run reset brings latch and watchdog back to power-up state
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    #1;
    chk("rerst_outs", outs, 8'h05);
    axr(STATUS_ADDR, 32'h4, RESP_OKAY);
    tally_and_finish();
  end
endmodule // multifunction_latch_watchdog_test

`default_nettype wire
